// >>> inc/hbd_pkg.sv
package hbd_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 40;
   localparam int DEAD_NS          = 200;
   localparam int DEGLITCH_NS      = 400;
   localparam int SENSE_DELAY_NS   = 1100;
   localparam int SLEEP_MIN_US     = 800;
   localparam int SLEEP_MAX_US     = 1500;
   localparam int SLEEP_US         = 1000;
   localparam int WAKE_MAX_US      = 250;
   localparam int WAKE_US          = 100;

   localparam int DEAD_CYC     = (DEAD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int SENSE_CYC    = (SENSE_DELAY_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int SLEEP_CYC    = SLEEP_US * 1000 / CLK_PERIOD_NS;
   localparam int WAKE_CYC     = WAKE_US * 1000 / CLK_PERIOD_NS;

   localparam int CNT_W = 16;

   // ---------------------------------------------------------------
   // Half-bridge drive and mode codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      HBD_HZ   = 3'b001,
      HBD_LOW  = 3'b010,
      HBD_HIGH = 3'b100
   } hbd_drive_t;

   typedef enum logic [2:0] {
      HBD_SLEEP  = 3'b001,
      HBD_WAKING = 3'b010,
      HBD_ACTIVE = 3'b100
   } hbd_mode_t;
endpackage : hbd_pkg

// >>> rtl/hbd_core.sv
`timescale 1ns/1ps
module hbd_core #(
   parameter int SLEEP_CYCLES = hbd_pkg::SLEEP_CYC,
   parameter int WAKE_CYCLES  = hbd_pkg::WAKE_CYC
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic ctrl_in_a,
   input  wire logic ctrl_in_b,
   output logic      bridge_out_a_hs_on,
   output logic      bridge_out_a_ls_on,
   output logic      bridge_out_b_hs_on,
   output logic      bridge_out_b_ls_on,
   output logic      current_sense_en,
   output logic      current_sense_valid,
   output logic      sleep_active
);
   import hbd_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisers and deglitch
   // ---------------------------------------------------------------
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   wire  [1:0] filt_q;
   logic [1:0] raw;
   assign raw = {ctrl_in_b, ctrl_in_a};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else if (clk_en) begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_dgl
         logic [CNT_W-1:0] dg_q;
         logic             level_q;
         assign filt_q[gi] = level_q;
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               dg_q    <= '0;
               level_q <= 1'b0;
            end else if (clk_en) begin
               if (sync_q[gi] == level_q) begin
                  dg_q <= '0;
               end else if (dg_q >= CNT_W'(DEGLITCH_CYC - 1)) begin
                  dg_q    <= '0;
                  level_q <= sync_q[gi];
               end else begin
                  dg_q <= dg_q + CNT_W'(1);
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sleep and wake control
   // ---------------------------------------------------------------
   hbd_mode_t        mode_q;
   logic [CNT_W-1:0] mode_cnt_q;
   logic             any_high;
   assign any_high = |filt_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_q     <= HBD_SLEEP;
         mode_cnt_q <= '0;
      end else if (clk_en) begin
         case (mode_q)
            HBD_SLEEP: begin
               mode_cnt_q <= '0;
               if (any_high) begin
                  mode_q <= HBD_WAKING;
               end
            end
            HBD_WAKING: begin
               if (!any_high) begin
                  mode_q     <= HBD_SLEEP;
                  mode_cnt_q <= '0;
               end else if (mode_cnt_q >= CNT_W'(WAKE_CYCLES - 1)) begin
                  mode_q     <= HBD_ACTIVE;
                  mode_cnt_q <= '0;
               end else begin
                  mode_cnt_q <= mode_cnt_q + CNT_W'(1);
               end
            end
            HBD_ACTIVE: begin
               if (any_high) begin
                  mode_cnt_q <= '0;
               end else if (mode_cnt_q >= CNT_W'(SLEEP_CYCLES - 1)) begin
                  mode_q     <= HBD_SLEEP;
                  mode_cnt_q <= '0;
               end else begin
                  mode_cnt_q <= mode_cnt_q + CNT_W'(1);
               end
            end
            default: begin
               mode_q     <= HBD_SLEEP;
               mode_cnt_q <= '0;
            end
         endcase
      end
   end

   assign sleep_active = (mode_q != HBD_ACTIVE);

   // ---------------------------------------------------------------
   // Wanted drive per half-bridge
   // ---------------------------------------------------------------
   hbd_drive_t want_a;
   hbd_drive_t want_b;

   always_comb begin
      want_a = HBD_HZ;
      want_b = HBD_HZ;
      if (mode_q == HBD_ACTIVE) begin
         case (filt_q)
            2'b01: begin
               want_a = HBD_HIGH;
               want_b = HBD_LOW;
            end
            2'b10: begin
               want_a = HBD_LOW;
               want_b = HBD_HIGH;
            end
            2'b11: begin
               want_a = HBD_LOW;
               want_b = HBD_LOW;
            end
            default: begin
               want_a = HBD_HZ;
               want_b = HBD_HZ;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Dead-time sequencing per half-bridge
   // ---------------------------------------------------------------
   hbd_drive_t       cur_q  [2];
   hbd_drive_t       want   [2];
   logic [CNT_W-1:0] dead_q [2];
   assign want[0] = want_a;
   assign want[1] = want_b;

   generate
      for (gi = 0; gi < 2; gi++) begin : g_half
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               cur_q[gi]  <= HBD_HZ;
               dead_q[gi] <= '0;
            end else if (clk_en) begin
               if (dead_q[gi] != '0) begin
                  dead_q[gi] <= dead_q[gi] - CNT_W'(1);
               end else if (want[gi] != cur_q[gi]) begin
                  if (cur_q[gi] == HBD_HZ) begin
                     cur_q[gi] <= want[gi];
                  end else begin
                     // Any release from drive starts a dead interval
                     cur_q[gi]  <= HBD_HZ;
                     dead_q[gi] <= CNT_W'(DEAD_CYC);
                  end
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bridge_out_a_hs_on <= 1'b0;
         bridge_out_a_ls_on <= 1'b0;
         bridge_out_b_hs_on <= 1'b0;
         bridge_out_b_ls_on <= 1'b0;
      end else if (clk_en) begin
         bridge_out_a_hs_on <= (cur_q[0] == HBD_HIGH);
         bridge_out_a_ls_on <= (cur_q[0] == HBD_LOW);
         bridge_out_b_hs_on <= (cur_q[1] == HBD_HIGH);
         bridge_out_b_ls_on <= (cur_q[1] == HBD_LOW);
      end
   end

   // ---------------------------------------------------------------
   // Current-sense gating
   // ---------------------------------------------------------------
   logic             ls_cmd;
   logic [CNT_W-1:0] sense_q;
   assign ls_cmd = (want_a == HBD_LOW) || (want_b == HBD_LOW);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         current_sense_en    <= 1'b0;
         current_sense_valid <= 1'b0;
         sense_q             <= '0;
      end else if (clk_en) begin
         current_sense_en <= ls_cmd;
         if (!ls_cmd) begin
            sense_q             <= '0;
            current_sense_valid <= 1'b0;
         end else if (sense_q >= CNT_W'(SENSE_CYC - 1)) begin
            current_sense_valid <= 1'b1;
         end else begin
            sense_q <= sense_q + CNT_W'(1);
         end
      end
   end
endmodule : hbd_core

// >>> tb/hbd_core_assertions.sv
`timescale 1ns/1ps
module hbd_core_assertions
   import hbd_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic ctrl_in_a,
   input wire logic ctrl_in_b,
   input wire logic bridge_out_a_hs_on,
   input wire logic bridge_out_a_ls_on,
   input wire logic bridge_out_b_hs_on,
   input wire logic bridge_out_b_ls_on,
   input wire logic current_sense_en,
   input wire logic current_sense_valid,
   input wire logic sleep_active
);
   logic [5:0] en_cnt_q;
   logic [4:0] low_cnt_q;
   wire        a_hs = bridge_out_a_hs_on;
   wire        a_ls = bridge_out_a_ls_on;
   wire        b_hs = bridge_out_b_hs_on;
   wire        b_ls = bridge_out_b_ls_on;
   // Cycles the sense gate has been open
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) en_cnt_q <= 6'h00;
      else if (!current_sense_en) en_cnt_q <= 6'h00;
      else if (en_cnt_q != 6'h3f) en_cnt_q <= en_cnt_q + 6'h01;
   end
   // Enabled cycles with both inputs low
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) low_cnt_q <= 5'h00;
      else if (ctrl_in_a || ctrl_in_b) low_cnt_q <= 5'h00;
      else if (clk_en && low_cnt_q != 5'h1f) low_cnt_q <= low_cnt_q + 5'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   shoot_a_a: assert property (!(a_hs && a_ls))
      else $error("out a both on");
   shoot_b_a: assert property (!(b_hs && b_ls))
      else $error("out b both on");
   both_high_a: assert property (!(a_hs && b_hs))
      else $error("both high sides on");
   dead_a_a: assert property ($fell(a_hs) |-> !a_ls [*6])
      else $error("no dead time on a");
   dead_a_ls_a: assert property ($fell(a_ls) |-> !a_hs [*6])
      else $error("no dead time on a low");
   dead_b_a: assert property ($fell(b_ls) |-> !b_hs [*6])
      else $error("no dead time on b");
   dead_b_hs_a: assert property ($fell(b_hs) |-> !b_ls [*6])
      else $error("no dead time on b high");
   sense_wait_a: assert property (current_sense_valid
      |-> en_cnt_q >= SENSE_CYC - 1)
      else $error("sense valid too early");
   valid_en_a: assert property (current_sense_valid
      |-> current_sense_en)
      else $error("valid without sense gate");
   sleep_off_a: assert property (sleep_active
      |-> !(a_hs || a_ls || b_hs || b_ls))
      else $error("switch on in sleep");
   sleep_hold_a: assert property (sleep_active
      && low_cnt_q >= 5'h0f |=> sleep_active)
      else $error("woke with inputs low");
endmodule : hbd_core_assertions
bind hbd_core hbd_core_assertions i_chk (.clock, .nrst, .clk_en,
   .ctrl_in_a, .ctrl_in_b, .bridge_out_a_hs_on, .bridge_out_a_ls_on,
   .bridge_out_b_hs_on, .bridge_out_b_ls_on, .current_sense_en,
   .current_sense_valid, .sleep_active);

// >>> tb/hbd_ctl_model.sv
`timescale 1ns/1ps
module hbd_ctl_model (
   input  wire logic       clock,
   input  wire logic [1:0] cmd,
   output logic            ctrl_in_a,
   output logic            ctrl_in_b
);
   logic [1:0] c;
   initial ctrl_in_a = 1'b0;
   initial ctrl_in_b = 1'b0;
   // Levels launched just after the edge, any cmd code: coast, drive either way or brake
   always @(posedge clock) begin
      c = cmd;
      #1;
      ctrl_in_a = c[1];
      ctrl_in_b = c[0];
   end
endmodule : hbd_ctl_model

// >>> tb/hbridge_input_decode_test.sv
`timescale 1ns/1ps
module hbridge_input_decode_test;
   import hbd_pkg::*;
   localparam logic [6:0] FWD = 7'h4e;
   localparam logic [6:0] REV = 7'h36;
   localparam logic [6:0] BRK = 7'h2e;
   localparam logic [6:0] SLP = 7'h01;
   localparam int WAKE_N  = 5;
   localparam int SLEEP_N = 40;
   // Settle windows, in clock edges after a command
   localparam int SWAP_LO = DEGLITCH_CYC + DEAD_CYC;
   localparam int SWAP_HI = SWAP_LO + 8;
   localparam int OFF_LO  = DEGLITCH_CYC;
   localparam int OFF_HI  = OFF_LO + 8;
   localparam int SNS_LO  = SENSE_CYC;
   localparam int SNS_HI  = SNS_LO + DEGLITCH_CYC + 8;
   localparam int WAKE_LO = SENSE_CYC + DEGLITCH_CYC;
   localparam int WAKE_HI = WAKE_LO + WAKE_N + 8;
   localparam int SLP_LO  = SLEEP_N + DEGLITCH_CYC;
   localparam int SLP_HI  = SLP_LO + 10;
   logic       clock = 1'b0;
   logic       nrst = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic       clk_en = 1'b1;
   logic       in_a, in_b, a_hs, a_ls, b_hs, b_ls, s_en, s_ok, slp;
   int         mismatches = 0;
   int         num_checks = 0;
   wire  [6:0] obs = {a_hs, a_ls, b_hs, b_ls, s_en, s_ok, slp};
   always #20 clock = ~clock;
   hbd_ctl_model i_ctl (.clock, .cmd, .ctrl_in_a(in_a), .ctrl_in_b(in_b));
   hbd_core #(.SLEEP_CYCLES(SLEEP_N), .WAKE_CYCLES(WAKE_N)) i_dut (
      .clock, .nrst, .clk_en, .ctrl_in_a(in_a), .ctrl_in_b(in_b),
      .bridge_out_a_hs_on(a_hs), .bridge_out_a_ls_on(a_ls),
      .bridge_out_b_hs_on(b_hs), .bridge_out_b_ls_on(b_ls),
      .current_sense_en(s_en), .current_sense_valid(s_ok),
      .sleep_active(slp));
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task check_obs(input logic [6:0] exp);
      num_checks++;
      if (obs !== exp) begin
         mismatches++;
         $display("MISMATCH %0t obs %b exp %b", $time, obs, exp);
      end
   endtask : check_obs
   task check_lat(input int n, input int lo, input int hi);
      num_checks++;
      if (n < lo || n > hi) begin
         mismatches++;
         $display("MISMATCH %0t latency %0d outside %0d..%0d",
                  $time, n, lo, hi);
      end
   endtask : check_lat
   // Command, wait for the result, judge latency, then one more edge
   task settle(input logic [1:0] c, input logic [6:0] exp,
               input int lo, input int hi);
      int n;
      @(posedge clock);
      #1 cmd = c;
      n = 0;
      while (obs !== exp && n < 300) begin
         @(posedge clock);
         #1 n++;
      end
      if (obs !== exp) begin
         mismatches++;
         $display("MISMATCH %0t settle timeout exp %b", $time, exp);
         final_report();
      end else begin
         check_lat(n, lo, hi);
         @(posedge clock);
      end
   endtask : settle
   task t_drive;
      settle(2'b10, FWD, WAKE_LO, WAKE_HI);
      #1 check_obs(FWD);
      settle(2'b01, REV, SWAP_LO, SWAP_HI);
      #1 check_obs(REV);
      settle(2'b11, BRK, SWAP_LO, SWAP_HI);
      #1 check_obs(BRK);
   endtask : t_drive
   task t_glitch;
      @(posedge clock);
      #1 cmd = 2'b01;
      repeat (4) @(posedge clock);
      #1 cmd = 2'b11;
      repeat (40) begin
         @(posedge clock);
         #1 if (obs !== BRK) check_obs(BRK);
      end
      check_obs(BRK);
   endtask : t_glitch
   task t_freeze;
      @(posedge clock);
      #1 clk_en = 1'b0;
      cmd = 2'b10;
      repeat (40) @(posedge clock);
      #1 check_obs(BRK);
      clk_en = 1'b1;
      settle(2'b10, FWD, SWAP_LO, SWAP_HI);
      #1 check_obs(FWD);
   endtask : t_freeze
   task t_pwm;
      repeat (3) begin
         #0 cmd = 2'b10;
         repeat (62) @(posedge clock);
         #1 check_obs(FWD);
         cmd = 2'b11;
         repeat (63) @(posedge clock);
         #1 check_obs(BRK);
      end
   endtask : t_pwm
   task t_coast;
      settle(2'b00, 7'h00, OFF_LO, OFF_HI);
      #1 check_obs(7'h00);
      settle(2'b11, BRK, SNS_LO, SNS_HI);
      #1 check_obs(BRK);
      settle(2'b00, SLP, SLP_LO, SLP_HI);
      #1 check_obs(SLP);
      settle(2'b01, REV, WAKE_LO, WAKE_HI);
      #1 check_obs(REV);
   endtask : t_coast
   initial begin
      repeat (4) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (30) @(posedge clock);
      #1 check_obs(SLP);
      t_drive();
      t_glitch();
      t_freeze();
      t_pwm();
      t_coast();
      final_report();
   end
endmodule : hbridge_input_decode_test
